// >>> include/cpdis_pkg.sv
//**************************************************************
// Purpose: shared constants and types of the charger port detect block
// Assumes: 50 MHz pclk, APB register access with 32-bit data
// Notes:   register byte address is four times the register index
//**************************************************************
package cpdis_pkg;
	//**************************************************************
	// timing
	//**************************************************************
	localparam longint CLK_HZ     = 50_000_000;
	localparam longint WDOG_S     = 50;                       // watchdog time, seconds
	localparam longint WDOG_CYC   = WDOG_S * CLK_HZ;
	localparam longint DCD_MS     = 600;                      // contact detect timeout, ms
	localparam longint DCD_CYC    = DCD_MS * CLK_HZ / 1000;
	localparam longint STEP_MS    = 40;                       // settle time of each step, ms
	localparam longint STEP_CYC   = STEP_MS * CLK_HZ / 1000;

	//**************************************************************
	// register map and fields
	//**************************************************************
	localparam logic [9:0]  CTRL_IDX      = 10'h004;
	localparam logic [9:0]  CLRV_IDX      = 10'h007;
	localparam logic [9:0]  STAT_IDX      = 10'h008;
	localparam int          WDOG_EN_BIT   = 0;
	localparam int          CHARGE_CURRENT_RESISTOR_PIN_EXT_BIT  = 1;
	localparam int          FORCE_BIT     = 4;
	localparam int          CLRV_BIT      = 4;
	localparam int          ST_PORT_LSB   = 0;
	localparam int          ST_DONE_BIT   = 3;
	localparam int          ST_HOST_BIT   = 4;
	localparam int          ST_FORCED_BIT = 5;
	localparam int          ST_DPLUS_BIT  = 6;
	localparam logic        WDOG_EN_RST   = 1'b1;
	localparam logic        CHARGE_CURRENT_RESISTOR_PIN_EXT_RST  = 1'b0;

	//**************************************************************
	// types
	//**************************************************************
	typedef enum logic [2:0] {
		PORT_NONE, PORT_DCP, PORT_CDP, PORT_SDP, PORT_NS
	} cpdis_port_t;
	typedef enum logic [2:0] {
		INPUT_LIMIT_RESISTOR_PIN_100, INPUT_LIMIT_RESISTOR_PIN_500, INPUT_LIMIT_RESISTOR_PIN_1500, INPUT_LIMIT_RESISTOR_PIN_2000, INPUT_LIMIT_RESISTOR_PIN_EXT, INPUT_LIMIT_RESISTOR_PIN_HIZ
	} cpdis_input_limit_resistor_pin_t;
	typedef enum logic [1:0] {DPM_THRESHOLD_PIN_436, DPM_THRESHOLD_PIN_468, DPM_THRESHOLD_PIN_EXT, DPM_THRESHOLD_PIN_NONE} cpdis_dpm_threshold_pin_t;
	typedef enum logic [1:0] {TMR_45M, TMR_6H, TMR_NONE} cpdis_tmr_t;

	// analog comparator and pin status, all asynchronous to pclk
	typedef struct packed {
		logic vbus_present;
		logic data_contact;
		logic primary_hi;
		logic secondary_hi;
		logic nonstd_match;
		logic battery_good;
		logic vin_good;
		logic input_limit_resistor_pin_short;
		logic input_limit_resistor_pin_float;
		logic charge_current_resistor_pin_short;
		logic dpm_threshold_pin_short;
		logic input_limit_resistor_pin_select_lo;
		logic input_limit_resistor_pin_select_hi;
	} cpdis_ana_t;

	typedef struct packed {
		cpdis_input_limit_resistor_pin_t input_limit_resistor_pin;
		cpdis_dpm_threshold_pin_t dpm_threshold_pin;
		cpdis_tmr_t  tmr;
	} cpdis_cfg_t;
endpackage

// >>> hw/cpdis_top.sv
//**************************************************************
// Purpose: port detection and input limit selection of a charger
// Assumes: analog comparators and pin straps arrive on ana_i
// Notes:   registers over APB, zero wait states
//**************************************************************
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module cpdis_top #(
	parameter logic [31:0] WDOG_CYCLES = 32'(cpdis_pkg::WDOG_CYC),
	parameter logic [31:0] DCD_CYCLES  = 32'(cpdis_pkg::DCD_CYC),
	parameter logic [31:0] STEP_CYCLES = 32'(cpdis_pkg::STEP_CYC)
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire cpdis_pkg::cpdis_ana_t ana_i,
	output cpdis_pkg::cpdis_cfg_t     cfg_o,
	output logic                      dplus_source_o,
	output logic                      charge_fault_o,
	output logic                      charge_suspend_o,
	output logic                      charge_zero_o,
	output logic                      power_good_n_o,
	output logic                      power_good_n_oe
);
	//**************************************************************
	// declarations
	//**************************************************************
	typedef enum {ST_IDLE, ST_DCD, ST_PRIMARY, ST_SEC_DCP, ST_SEC_SDP,
		ST_NONSTD, ST_CONFIG, ST_DONE} cpdis_st_t;

	cpdis_pkg::cpdis_ana_t  ana_m_r, ana_s_r;
	cpdis_st_t              st_r;
	cpdis_pkg::cpdis_port_t port_r, app_port_r;
	cpdis_pkg::cpdis_cfg_t  cfg_nxt;
	logic [31:0]            cnt_r, wd_cnt_r;
	logic                   vbus_d_r, host_r, wdog_en_r, charge_current_resistor_pin_ext_r;
	logic                   force_r, forced_r, det_done_r, dplus_clr_r;
	logic                   sel_act_r;
	logic [1:0]             sel_snap_r;
	logic                   setup, access, wr_acc, hit, start, step_done;
	logic                   wr_force, wr_clrv;
	logic [31:0]            rd_nxt;

	//**************************************************************
	// input synchroniser and apb decode
	//**************************************************************
	// whole status bundle through two flops; only the second is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana_m_r <= '0;
			ana_s_r <= '0;
			vbus_d_r <= 1'b0;
		end else begin
			ana_m_r <= ana_i;
			ana_s_r <= ana_m_r;
			vbus_d_r <= ana_s_r.vbus_present;
		end
	end

	assign setup    = psel && !penable;
	assign access   = psel && penable;
	assign hit      = (paddr[11:2] == cpdis_pkg::CTRL_IDX) ||
	                  (paddr[11:2] == cpdis_pkg::CLRV_IDX) ||
	                  (paddr[11:2] == cpdis_pkg::STAT_IDX);
	assign wr_acc   = access && pwrite;
	assign wr_force = wr_acc && (paddr[11:2] == cpdis_pkg::CTRL_IDX) &&
	                  pwdata[cpdis_pkg::FORCE_BIT];
	assign wr_clrv  = wr_acc && (paddr[11:2] == cpdis_pkg::CLRV_IDX) &&
	                  pwdata[cpdis_pkg::CLRV_BIT];
	assign pready   = 1'b1;
	assign pslverr  = access && !hit;

	// read data captured in setup so it comes from a flop in access
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (paddr[11:2])
			cpdis_pkg::CTRL_IDX: begin
				rd_nxt[cpdis_pkg::WDOG_EN_BIT]  = wdog_en_r;
				rd_nxt[cpdis_pkg::CHARGE_CURRENT_RESISTOR_PIN_EXT_BIT] = charge_current_resistor_pin_ext_r;
				rd_nxt[cpdis_pkg::FORCE_BIT]    = force_r;
			end
			cpdis_pkg::CLRV_IDX: rd_nxt[cpdis_pkg::CLRV_BIT] = dplus_source_o;
			cpdis_pkg::STAT_IDX: begin
				rd_nxt[cpdis_pkg::ST_PORT_LSB +: 3] = port_r;
				rd_nxt[cpdis_pkg::ST_DONE_BIT]      = det_done_r;
				rd_nxt[cpdis_pkg::ST_HOST_BIT]      = host_r;
				rd_nxt[cpdis_pkg::ST_FORCED_BIT]    = forced_r;
				rd_nxt[cpdis_pkg::ST_DPLUS_BIT]     = dplus_source_o;
			end
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_nxt;
		end
	end

	//**************************************************************
	// control register and host mode
	//**************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_en_r  <= cpdis_pkg::WDOG_EN_RST;
			charge_current_resistor_pin_ext_r <= cpdis_pkg::CHARGE_CURRENT_RESISTOR_PIN_EXT_RST;
		end else if (wr_acc && paddr[11:2] == cpdis_pkg::CTRL_IDX) begin
			wdog_en_r  <= pwdata[cpdis_pkg::WDOG_EN_BIT];
			charge_current_resistor_pin_ext_r <= pwdata[cpdis_pkg::CHARGE_CURRENT_RESISTOR_PIN_EXT_BIT];
		end
	end

	// any access reloads the watchdog; expiry drops back to standalone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_r   <= 1'b0;
			wd_cnt_r <= 32'h0000_0000;
		end else if (access) begin
			host_r   <= 1'b1;
			wd_cnt_r <= WDOG_CYCLES - 32'h0000_0001;
		end else if (host_r && wdog_en_r) begin
			if (wd_cnt_r == 32'h0000_0000) begin
				host_r <= 1'b0;
			end else begin
				wd_cnt_r <= wd_cnt_r - 32'h0000_0001;
			end
		end
	end

	// pending force request; a new write wins over the clear at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= 1'b0;
		end else begin
			if (start) begin
				force_r <= 1'b0;
			end
			if (wr_force) begin
				force_r <= 1'b1;
			end
		end
	end

	//**************************************************************
	// detection sequence
	//**************************************************************
	assign start = (st_r == ST_IDLE || st_r == ST_DONE) &&
	               (force_r || (ana_s_r.vbus_present && !vbus_d_r && !host_r));
	assign step_done = (cnt_r >= STEP_CYCLES - 32'h0000_0001);

	// state, its dwell counter and the detected port type
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r   <= ST_IDLE;
			cnt_r  <= 32'h0000_0000;
			port_r <= cpdis_pkg::PORT_NONE;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
			case (st_r)
				ST_IDLE, ST_DONE: begin
					if (start) begin
						st_r  <= ST_DCD;
						cnt_r <= 32'h0000_0000;
					end
				end
				ST_DCD: begin
					if (ana_s_r.data_contact) begin
						st_r  <= ST_PRIMARY;
						cnt_r <= 32'h0000_0000;
					end else if (cnt_r >= DCD_CYCLES - 32'h0000_0001) begin
						st_r  <= ST_NONSTD;
						cnt_r <= 32'h0000_0000;
					end
				end
				ST_PRIMARY: begin
					if (step_done) begin
						st_r  <= ana_s_r.primary_hi ? ST_SEC_DCP : ST_SEC_SDP;
						cnt_r <= 32'h0000_0000;
					end
				end
				ST_SEC_DCP: begin
					if (step_done) begin
						port_r <= ana_s_r.secondary_hi ? cpdis_pkg::PORT_DCP
						                               : cpdis_pkg::PORT_CDP;
						st_r   <= ST_CONFIG;
					end
				end
				ST_SEC_SDP: begin
					// unidentified ports such as accessory adapters land on the 500 mA type
					if (step_done) begin
						port_r <= ana_s_r.secondary_hi ? cpdis_pkg::PORT_NS
						                               : cpdis_pkg::PORT_SDP;
						st_r   <= ST_CONFIG;
					end
				end
				ST_NONSTD: begin
					if (step_done) begin
						cnt_r <= 32'h0000_0000;
						if (ana_s_r.nonstd_match) begin
							port_r <= cpdis_pkg::PORT_NS;
							st_r   <= ST_CONFIG;
						end else begin
							st_r   <= ST_PRIMARY;
						end
					end
				end
				ST_CONFIG: st_r <= ST_DONE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// completion flag and the port type that actually steers the limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_done_r <= 1'b0;
			forced_r   <= 1'b0;
			app_port_r <= cpdis_pkg::PORT_NONE;
		end else begin
			if (start) begin
				det_done_r <= 1'b0;
				forced_r   <= force_r && host_r;
			end
			if (st_r == ST_CONFIG) begin
				det_done_r <= 1'b1;
				if (!forced_r) begin
					app_port_r <= port_r;
				end
			end
		end
	end

	// select pins only take over after a change seen past detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_act_r  <= 1'b0;
			sel_snap_r <= 2'b00;
		end else if (start) begin
			sel_act_r  <= 1'b0;
		end else if (st_r == ST_CONFIG) begin
			sel_snap_r <= {ana_s_r.input_limit_resistor_pin_select_hi, ana_s_r.input_limit_resistor_pin_select_lo};
		end else if (det_done_r &&
		             sel_snap_r != {ana_s_r.input_limit_resistor_pin_select_hi, ana_s_r.input_limit_resistor_pin_select_lo}) begin
			sel_act_r  <= 1'b1;
		end
	end

	//**************************************************************
	// limit, threshold and timer selection
	//**************************************************************
	// before any detection the safe 100 mA setting holds
	always_comb begin
		cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436, cpdis_pkg::TMR_45M};
		if (sel_act_r) begin
			case ({ana_s_r.input_limit_resistor_pin_select_hi, ana_s_r.input_limit_resistor_pin_select_lo})
				2'b00: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_500, cpdis_pkg::DPM_THRESHOLD_PIN_436,
				                   cpdis_pkg::TMR_6H};
				2'b01: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_EXT, cpdis_pkg::DPM_THRESHOLD_PIN_EXT,
				                   cpdis_pkg::TMR_6H};
				2'b10: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436,
				                   cpdis_pkg::TMR_6H};
				default: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_HIZ, cpdis_pkg::DPM_THRESHOLD_PIN_NONE,
				                     cpdis_pkg::TMR_NONE};
			endcase
		end else if (det_done_r || app_port_r != cpdis_pkg::PORT_NONE) begin
			case (app_port_r)
				cpdis_pkg::PORT_DCP: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_EXT,
				                     cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_6H};
				cpdis_pkg::PORT_CDP: cfg_nxt = ana_s_r.battery_good ?
				    '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_1500, cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_6H} :
				    '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_45M};
				cpdis_pkg::PORT_SDP: cfg_nxt = ana_s_r.battery_good ?
				    '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_HIZ, cpdis_pkg::DPM_THRESHOLD_PIN_NONE, cpdis_pkg::TMR_NONE} :
				    '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_45M};
				cpdis_pkg::PORT_NS: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_500,
				                    cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_6H};
				default: cfg_nxt = '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436,
				                     cpdis_pkg::TMR_45M};
			endcase
		end
		// a shorted resistor pin stands for the internal default
		if (cfg_nxt.input_limit_resistor_pin == cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_EXT && ana_s_r.input_limit_resistor_pin_short) begin
			cfg_nxt.input_limit_resistor_pin = cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_2000;
		end
		if (cfg_nxt.dpm_threshold_pin == cpdis_pkg::DPM_THRESHOLD_PIN_EXT && ana_s_r.dpm_threshold_pin_short) begin
			cfg_nxt.dpm_threshold_pin = cpdis_pkg::DPM_THRESHOLD_PIN_468;
		end
	end

	//**************************************************************
	// registered outputs
	//**************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_o <= '{cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436, cpdis_pkg::TMR_45M};
			charge_fault_o   <= 1'b0;
			charge_suspend_o <= 1'b0;
			charge_zero_o    <= 1'b0;
			power_good_n_oe  <= 1'b0;
		end else begin
			cfg_o            <= cfg_nxt;
			charge_fault_o   <= ana_s_r.charge_current_resistor_pin_short;
			charge_suspend_o <= ana_s_r.charge_current_resistor_pin_short;
			charge_zero_o    <= ana_s_r.input_limit_resistor_pin_float && charge_current_resistor_pin_ext_r;
			power_good_n_oe  <= det_done_r && ana_s_r.vin_good;
		end
	end
	assign power_good_n_o = 1'b0;

	// d+ source while waking a dead battery; software clear stays until re-detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dplus_clr_r    <= 1'b0;
			dplus_source_o <= 1'b0;
		end else begin
			if (start) begin
				dplus_clr_r <= 1'b0;
			end
			if (wr_clrv) begin
				dplus_clr_r <= 1'b1;
			end
			dplus_source_o <= det_done_r && !ana_s_r.battery_good && !dplus_clr_r &&
			                  (app_port_r == cpdis_pkg::PORT_CDP ||
			                   app_port_r == cpdis_pkg::PORT_SDP);
		end
	end

	//**************************************************************
	// assertions
	//**************************************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	pg_gate_a: assert property (!det_done_r |=> !power_good_n_oe)
		else $error("power good driven before detection done");
	dcd_timeout_a: assert property ((st_r == ST_DCD && !ana_s_r.data_contact &&
		cnt_r == DCD_CYCLES - 32'h0000_0001) |=> st_r == ST_NONSTD)
		else $error("contact timeout did not go to nonstandard detection");
	nonstd_fail_a: assert property ((st_r == ST_NONSTD && step_done &&
		!ana_s_r.nonstd_match) |=> st_r == ST_PRIMARY)
		else $error("failed nonstandard check did not return to primary");
	force_entry_a: assert property ((wr_force && (st_r == ST_IDLE || st_r == ST_DONE))
		|=> ##1 st_r == ST_DCD)
		else $error("force write did not start detection");
	standalone_a: assert property (((st_r == ST_IDLE || st_r == ST_DONE) && host_r && !force_r)
		|=> st_r != ST_DCD)
		else $error("automatic detection started in host mode");
	forced_keep_a: assert property ((st_r == ST_CONFIG && forced_r)
		|=> app_port_r == $past(app_port_r))
		else $error("forced detection changed applied port");
	done_flag_a: assert property ((st_r == ST_CONFIG) |=> det_done_r ##1 det_done_r)
		else $error("done flag not set at configuration");
	sel_table_a: assert property ((sel_act_r && !ana_s_r.input_limit_resistor_pin_select_hi &&
		!ana_s_r.input_limit_resistor_pin_select_lo) |=> cfg_o.input_limit_resistor_pin == cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_500 &&
		cfg_o.dpm_threshold_pin == cpdis_pkg::DPM_THRESHOLD_PIN_436)
		else $error("select 00 did not give 500 mA at 4.36 V");
	charge_current_resistor_pin_fault_a: assert property (ana_s_r.charge_current_resistor_pin_short |=> charge_suspend_o && charge_fault_o)
		else $error("shorted charge current pin did not suspend");
	zero_charge_a: assert property ((ana_s_r.input_limit_resistor_pin_float && charge_current_resistor_pin_ext_r) |=> charge_zero_o)
		else $error("floating limit pin did not zero charge current");
	dplus_clear_a: assert property (wr_clrv |=> ##1 !dplus_source_o)
		else $error("d+ source not cleared by write");
endmodule

// >>> test/cpdis_port_model.sv
// Purpose: far side of the port detector, a usb port or wall adapter
// Assumes: comparator outputs are levels seen through the design's synchronisers
// Notes:   slow means the data pins never make contact, so contact detect times out
`timescale 1ns/1ps
module cpdis_port_model (
	input  wire logic                   vbus,
	input  wire logic                   slow,
	input  wire cpdis_pkg::cpdis_port_t kind,
	output logic                        contact,
	output logic                        primary_hi,
	output logic                        secondary_hi,
	output logic                        nonstd_match
);
	//********************
	// comparator levels by port kind
	//********************
	// without vbus the d+/d- pull-downs win, so every comparator reads low
	always_comb begin
		contact      = vbus && !slow;
		primary_hi   = vbus && (kind == cpdis_pkg::PORT_DCP || kind == cpdis_pkg::PORT_CDP);
		secondary_hi = vbus && (kind == cpdis_pkg::PORT_DCP || kind == cpdis_pkg::PORT_NS);
		nonstd_match = vbus && kind == cpdis_pkg::PORT_NS;
	end
endmodule

// >>> test/tb_top.sv
// Purpose: self-checking bench of the port detect and limit select block
// Assumes: short watchdog, contact and step counts so a run stays brief
// Notes:   vin_good is held high; apb access puts the block in host mode
`timescale 1ns/1ps
module tb_top;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic                   vbus, slow, bg, ils, ilf, iss, vds, slo, shi;
	logic                   dc, ph, sh, nm, dp, cf, cs, cz, pgn, pg;
	cpdis_pkg::cpdis_port_t kind;
	cpdis_pkg::cpdis_ana_t  ana;
	cpdis_pkg::cpdis_cfg_t  cfg;
	int                     num_errors, n_checks;
	assign ana = {vbus, dc, ph, sh, nm, bg, 1'b1, ils, ilf, iss, vds, slo, shi};
	cpdis_top #(.WDOG_CYCLES(32'd200), .DCD_CYCLES(32'd50), .STEP_CYCLES(32'd8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ana_i(ana), .cfg_o(cfg), .dplus_source_o(dp), .charge_fault_o(cf),
		.charge_suspend_o(cs), .charge_zero_o(cz), .power_good_n_o(pgn), .power_good_n_oe(pg));
	cpdis_port_model PM (.vbus(vbus), .slow(slow), .kind(kind), .contact(dc),
		.primary_hi(ph), .secondary_hi(sh), .nonstd_match(nm));
	//********************
	// helpers
	//********************
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// sample 1 ns after the edge so the design's flops have landed
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task wait_pg(input logic lv);
		int i;
		for (i = 0; i < 400; i++) begin
			if (pg === lv) break;
			tick(1);
		end
		if (pg !== lv) begin
			chk(32'(pg), 32'(lv));
			stop_test();
		end
	endtask
	// one apb transfer; request held until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			chk(32'(pready), 32'h1);
			stop_test();
		end
	endtask
	// expected limits after a detection, worked out from the port table
	function logic [31:0] exp_cfg(input cpdis_pkg::cpdis_port_t k, input logic b, input logic x);
		cpdis_pkg::cpdis_cfg_t c;
		c.dpm_threshold_pin = x ? cpdis_pkg::DPM_THRESHOLD_PIN_468 : cpdis_pkg::DPM_THRESHOLD_PIN_EXT;
		c.tmr = cpdis_pkg::TMR_6H;
		c.input_limit_resistor_pin = (k == cpdis_pkg::PORT_CDP) ? cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_1500 : cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_HIZ;
		if (k == cpdis_pkg::PORT_DCP) c.input_limit_resistor_pin = x ? cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_2000 : cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_EXT;
		if (k == cpdis_pkg::PORT_NS) c.input_limit_resistor_pin = cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_500;
		if (!b && k inside {cpdis_pkg::PORT_CDP, cpdis_pkg::PORT_SDP}) begin
			c.input_limit_resistor_pin = cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100;
			c.tmr = cpdis_pkg::TMR_45M;
		end else if (k == cpdis_pkg::PORT_SDP) begin
			// hi-z input leaves no voltage loop to regulate
			c.dpm_threshold_pin = cpdis_pkg::DPM_THRESHOLD_PIN_NONE;
			c.tmr = cpdis_pkg::TMR_NONE;
		end
		return 32'(c);
	endfunction
	//********************
	// scenarios
	//********************
	task t_auto(input cpdis_pkg::cpdis_port_t k, input logic s, input logic b, input logic x);
		@(posedge pclk);
		vbus <= 1'b0;
		tick(4);
		@(posedge pclk);
		kind <= k;
		slow <= s;
		bg <= b;
		ils <= x;
		vds <= x;
		vbus <= 1'b1;
		wait_pg(1'b0);
		tick(10);
		chk(32'(pg), 32'h0);
		wait_pg(1'b1);
		tick(2);
		chk(32'(cfg), exp_cfg(k, b, x));
		chk(32'(dp), 32'(!b && k inside {cpdis_pkg::PORT_CDP, cpdis_pkg::PORT_SDP}));
		$display("test auto %0d done", k);
	endtask
	task t_force;
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0000_0001);
		@(posedge pclk);
		kind <= cpdis_pkg::PORT_CDP;
		apb(1'b1, 12'h010, 32'h0000_0011);
		wait_pg(1'b0);
		wait_pg(1'b1);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0000_003A);
		chk(32'(cfg), exp_cfg(cpdis_pkg::PORT_DCP, 1'b1, 1'b0));
		@(posedge pclk);
		vbus <= 1'b0;
		tick(4);
		@(posedge pclk);
		vbus <= 1'b1;
		// a wrongly started detection would hold power good off here
		tick(10);
		chk(32'(pg), 32'h1);
		$display("test force done");
	endtask
	task t_sel;
		static logic [1:0] seq [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
		static logic [31:0] e [4] = '{{25'h0, cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436, cpdis_pkg::TMR_6H},
			{25'h0, cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_EXT, cpdis_pkg::DPM_THRESHOLD_PIN_EXT, cpdis_pkg::TMR_6H},
			{25'h0, cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_HIZ, cpdis_pkg::DPM_THRESHOLD_PIN_NONE, cpdis_pkg::TMR_NONE},
			{25'h0, cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_500, cpdis_pkg::DPM_THRESHOLD_PIN_436, cpdis_pkg::TMR_6H}};
		for (int j = 0; j < 4; j++) begin
			@(posedge pclk);
			shi <= seq[j][1];
			slo <= seq[j][0];
			tick(6);
			chk(32'(cfg), e[j]);
		end
		$display("test selects done");
	endtask
	task t_clear;
		tick(250);
		t_auto(cpdis_pkg::PORT_CDP, 1'b0, 1'b0, 1'b0);
		// the host side connects right after detection, far inside the deadline
		apb(1'b1, 12'h01C, 32'h0000_0010);
		tick(3);
		chk(32'(dp), 32'h0);
		apb(1'b0, 12'h03C, 32'h0);
		chk({rd[31:1], err}, 32'h1);
		$display("test clear done");
	endtask
	task t_faults;
		@(posedge pclk);
		iss <= 1'b1;
		tick(4);
		chk(32'({cf, cs}), 32'h3);
		@(posedge pclk);
		iss <= 1'b0;
		ilf <= 1'b1;
		apb(1'b1, 12'h010, 32'h0000_0003);
		tick(4);
		chk(32'({cz, cf}), 32'h2);
		apb(1'b1, 12'h010, 32'h0000_0001);
		tick(4);
		chk(32'(cz), 32'h0);
		$display("test faults done");
	endtask
	//********************
	// main sequence
	//********************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, rd, err} = '0;
		{vbus, slow, bg, ils, ilf, iss, vds, slo, shi} = '0;
		kind = cpdis_pkg::PORT_NONE;
		num_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		chk(32'(cfg), {25'h0, cpdis_pkg::INPUT_LIMIT_RESISTOR_PIN_100, cpdis_pkg::DPM_THRESHOLD_PIN_436, cpdis_pkg::TMR_45M});
		chk(32'({pg, pgn}), 32'h0);
		t_auto(cpdis_pkg::PORT_CDP, 1'b0, 1'b1, 1'b0);
		t_auto(cpdis_pkg::PORT_SDP, 1'b0, 1'b1, 1'b0);
		t_auto(cpdis_pkg::PORT_SDP, 1'b0, 1'b0, 1'b0);
		t_auto(cpdis_pkg::PORT_NS, 1'b0, 1'b1, 1'b0);
		t_auto(cpdis_pkg::PORT_NS, 1'b1, 1'b1, 1'b0);
		t_auto(cpdis_pkg::PORT_SDP, 1'b1, 1'b1, 1'b0);
		t_auto(cpdis_pkg::PORT_DCP, 1'b0, 1'b1, 1'b1);
		t_auto(cpdis_pkg::PORT_DCP, 1'b0, 1'b1, 1'b0);
		t_force;
		t_sel;
		t_clear;
		t_faults;
		stop_test();
	end
endmodule
